// >>> logic/dsptu_pkg.sv
// dual-slope pwm timer unit: register map, field positions, modes and bus carrier
// assumes a 32-bit classic wishbone slave with byte data in lane 0
package dsptu_pkg;
  // register byte addresses
  localparam logic [7:0] ADR_CTRL_A = 8'h00;
  localparam logic [7:0] ADR_CTRL_B = 8'h04;
  localparam logic [7:0] ADR_COUNT = 8'h08;
  localparam logic [7:0] ADR_CMP_A = 8'h0C;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h14;
  // field positions and writable masks
  localparam int CA_ACT_A_LSB = 6;
  localparam int CA_MODE_LSB = 0;
  localparam int CB_FORCE_A = 7;
  localparam int CB_MODE_HI = 3;
  localparam int CB_CS_LSB = 0;
  localparam logic [7:0] CTRL_A_WR_MASK = 8'hF3;
  localparam logic [7:0] CTRL_B_WR_MASK = 8'h0F;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] IRQ_WR_MASK = 2'h3;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_CMPA = 1;
  // counter limits and period
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam int PC_PERIOD_TICKS = 510;
  // waveform mode selections
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PC_MAX = 3'h1;
  localparam logic [2:0] MODE_CTC = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX = 3'h3;
  localparam logic [2:0] MODE_PC_CMP = 3'h5;
  localparam logic [2:0] MODE_FAST_CMP = 3'h7;
  // output actions
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // prescale factors 8 to 256 for clock select codes 2..6; the 1024 mask is not used by any code
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_32 = 10'h01F;
  localparam logic [9:0] PRE_MASK_64 = 10'h03F;
  localparam logic [9:0] PRE_MASK_128 = 10'h07F;
  localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;
  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dsptu_dir_e;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } dsptu_wb_req_s;
endpackage

// >>> logic/dsptu_top.sv
// dual-slope pwm timer unit: counter, waveform generator for channel a, flags, irq, wishbone slave
// assumes one clock, synchronous active-high reset, a classic wishbone master
//
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - mode selections 1 and 5 make the counter run up from bottom to top and back down, over and over.
// - in the dual-slope modes top is 0xFF for selection 1 and the channel a compare value for selection 5.
// - the counter climbs until it equals top, stays there for one tick, then starts counting down.
// - in dual-slope mode the overflow flag is set each time the counter reaches bottom and may raise the irq.
// - non-inverting dual-slope output clears on an up match and sets on a down match, inverting does the reverse.
// - a compare value of bottom gives a steady low and max a steady high when non-inverted, opposite when inverted.
// - when the compare value leaves max, the output is moved to the up-match level at bottom with no match.
// - if counting runs above the compare value on the way up, the missed up-match level is still applied.
// - with top at max one dual-slope period is 510 ticks and the tick is the clock divided by 1 to 256.
// - the tick is a clock enable on the system clock; an oscillator clock source is not built here.
// - a nonzero channel a action routes the output to the pin, except action 1 in pwm without the mode high bit; software must set the pin direction too.
// - outside pwm modes action 0 disconnects, 1 toggles, 2 clears and 3 sets the output on a match.
// - in single-slope pwm action 1 toggles only with the mode high bit, 2 clears on match and sets at top, 3 reverse.
// - in dual-slope pwm action 1 toggles only with the mode high bit, 2 clears up and sets down, 3 reverse.
// - in pwm with compare equal to top and the action high bit set, the match is ignored but the top action runs.
// - the mode selection joins the two low bits of control a with bit 3 of control b.
module dsptu_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire dsptu_pkg::dsptu_wb_req_s wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // compare output pin and interrupt
  output logic compare_output_a_o,
  output logic compare_output_a_oe_o,
  output logic irq_o
);
  import dsptu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic tick_of(input logic [2:0] cs, input logic [9:0] pre);
    logic t;
    t = 1'b0;
    case (cs)
      3'h1: t = 1'b1;
      3'h2: t = (pre & PRE_MASK_8) == PRE_MASK_8;
      3'h3: t = (pre & PRE_MASK_32) == PRE_MASK_32;
      3'h4: t = (pre & PRE_MASK_64) == PRE_MASK_64;
      3'h5: t = (pre & PRE_MASK_128) == PRE_MASK_128;
      3'h6: t = (pre & PRE_MASK_256) == PRE_MASK_256;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  function automatic logic apply_act(input logic cur, input logic [1:0] act);
    logic r;
    r = cur;
    case (act)
      ACT_TOGGLE: r = ~cur;
      ACT_CLEAR: r = 1'b0;
      ACT_SET: r = 1'b1;
      default: r = cur;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] waveform_control_a_reg;
  logic [7:0] waveform_control_b_reg;
  logic [7:0] count_value_reg;
  logic [7:0] cmp_buf_reg;
  logic [7:0] compare_value_a_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic [9:0] pre_reg;
  logic was_max_reg;
  dsptu_dir_e dir_reg;
  dsptu_dir_e dir_next;
  logic [7:0] count_next;
  logic out_next;
  logic [2:0] waveform_mode_select;
  logic [1:0] output_a_action;
  logic mode_select_high_bit;
  logic is_pc;
  logic is_fast;
  logic is_pwm;
  logic [7:0] top;
  logic timer_tick;
  logic match;
  logic ignore_match;
  logic ovf_evt;
  logic upd_evt;
  logic turn_evt;
  logic take;
  logic wr;
  logic rd;
  logic force_a;
  logic up_lvl;
  logic oe_next;

  assign waveform_mode_select = {waveform_control_b_reg[CB_MODE_HI],
                                 waveform_control_a_reg[CA_MODE_LSB +: 2]};
  assign mode_select_high_bit = waveform_mode_select[2];
  assign output_a_action = waveform_control_a_reg[CA_ACT_A_LSB +: 2];
  assign is_pc = (waveform_mode_select == MODE_PC_MAX) || (waveform_mode_select == MODE_PC_CMP);
  assign is_fast = (waveform_mode_select == MODE_FAST_MAX) || (waveform_mode_select == MODE_FAST_CMP);
  assign is_pwm = is_pc || is_fast;
  assign top = (waveform_mode_select == MODE_PC_CMP || waveform_mode_select == MODE_FAST_CMP ||
                waveform_mode_select == MODE_CTC) ? compare_value_a_reg : CNT_MAX;
  assign timer_tick = tick_of(waveform_control_b_reg[CB_CS_LSB +: 3], pre_reg);
  assign match = count_value_reg == compare_value_a_reg;
  assign ignore_match = is_pwm && output_a_action[1] && (compare_value_a_reg == top);
  assign up_lvl = output_a_action[0];
  assign take = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
  assign wr = take && wb_req_i.we && wb_req_i.sel[0];
  assign rd = take && !wb_req_i.we;
  assign force_a = wr && (wb_req_i.adr == ADR_CTRL_B) && wb_req_i.dat[CB_FORCE_A] && !is_pwm;

  ////////////////////////////////////////////////////////////////////////////
  // counting sequence
  always_comb begin
    count_next = count_value_reg;
    dir_next = dir_reg;
    ovf_evt = 1'b0;
    upd_evt = 1'b0;
    turn_evt = 1'b0;
    if (timer_tick) begin
      if (is_pc) begin
        if (count_value_reg == CNT_BOTTOM) begin
          dir_next = DIR_UP;
          if (top != CNT_BOTTOM) begin
            count_next = count_value_reg + CNT_ONE;
          end
        end else if (dir_reg == DIR_UP) begin
          if (count_value_reg >= top) begin
            turn_evt = 1'b1;
            upd_evt = 1'b1;
            dir_next = DIR_DOWN;
            count_next = count_value_reg - CNT_ONE;
          end else begin
            count_next = count_value_reg + CNT_ONE;
          end
        end else begin
          count_next = count_value_reg - CNT_ONE;
          ovf_evt = count_value_reg == CNT_ONE;
        end
      end else if (is_fast) begin
        if (count_value_reg >= top) begin
          count_next = CNT_BOTTOM;
          ovf_evt = 1'b1;
          upd_evt = 1'b1;
        end else begin
          count_next = count_value_reg + CNT_ONE;
        end
      end else begin
        dir_next = DIR_UP;
        ovf_evt = count_value_reg == CNT_MAX;
        if (waveform_mode_select == MODE_CTC && match) begin
          count_next = CNT_BOTTOM;
        end else begin
          count_next = count_value_reg + CNT_ONE;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // waveform generator for channel a
  always_comb begin
    out_next = compare_output_a_o;
    if (force_a) begin
      out_next = apply_act(compare_output_a_o, output_a_action);
    end else if (timer_tick) begin
      if (!is_pwm) begin
        if (match) begin
          out_next = apply_act(compare_output_a_o, output_a_action);
        end
      end else if (output_a_action == ACT_TOGGLE) begin
        if (mode_select_high_bit && match) begin
          out_next = ~compare_output_a_o;
        end
      end else if (output_a_action[1] && is_fast) begin
        if (count_value_reg >= top) begin
          out_next = ~up_lvl;
        end else if (match && !ignore_match) begin
          out_next = up_lvl;
        end
      end else if (output_a_action[1]) begin
        if (dir_reg == DIR_UP || count_value_reg == CNT_BOTTOM) begin
          if (turn_evt && ignore_match) begin
            out_next = ~up_lvl;
          end else if (match && !ignore_match) begin
            out_next = up_lvl;
          end else if (count_value_reg > compare_value_a_reg) begin
            out_next = up_lvl;
          end else if (count_value_reg == CNT_BOTTOM && was_max_reg && compare_value_a_reg != CNT_MAX) begin
            out_next = up_lvl;
          end
        end else if (match && !ignore_match) begin
          out_next = ~up_lvl;
        end
      end
    end
  end

  assign oe_next = (output_a_action != ACT_OFF) &&
                   !(is_pwm && output_a_action == ACT_TOGGLE && !mode_select_high_bit);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 10'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_value_reg <= RST_BYTE;
      dir_reg <= DIR_UP;
      was_max_reg <= 1'b0;
    end else begin
      dir_reg <= dir_next;
      if (wr && wb_req_i.adr == ADR_COUNT) begin
        count_value_reg <= wb_req_i.dat[7:0];
      end else begin
        count_value_reg <= count_next;
      end
      if (turn_evt) begin
        was_max_reg <= compare_value_a_reg == CNT_MAX;
      end else if (timer_tick && count_value_reg == CNT_BOTTOM) begin
        was_max_reg <= 1'b0;
      end
    end
  end

  // compare value: immediate outside pwm, taken at top in pwm
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_value_a_reg <= RST_BYTE;
    end else if (!is_pwm || upd_evt) begin
      compare_value_a_reg <= cmp_buf_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_output_a_o <= 1'b0;
      compare_output_a_oe_o <= 1'b0;
    end else begin
      compare_output_a_o <= out_next;
      compare_output_a_oe_o <= oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, flags and wishbone answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      waveform_control_a_reg <= RST_BYTE;
      waveform_control_b_reg <= RST_BYTE;
      cmp_buf_reg <= RST_BYTE;
      irq_mask_reg <= '0;
    end else if (wr) begin
      case (wb_req_i.adr)
        ADR_CTRL_A: waveform_control_a_reg <= wb_req_i.dat[7:0] & CTRL_A_WR_MASK;
        ADR_CTRL_B: waveform_control_b_reg <= wb_req_i.dat[7:0] & CTRL_B_WR_MASK;
        ADR_CMP_A: cmp_buf_reg <= wb_req_i.dat[7:0];
        ADR_IRQ_MASK: irq_mask_reg <= wb_req_i.dat[1:0] & IRQ_WR_MASK;
        default: cmp_buf_reg <= cmp_buf_reg;
      endcase
    end
  end

  // read clears status; a new event in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= '0;
    end else begin
      if (rd && wb_req_i.adr == ADR_IRQ_STAT) begin
        irq_stat_reg <= '0;
      end
      if (ovf_evt) begin
        irq_stat_reg[IRQ_OVF] <= 1'b1;
      end
      if (timer_tick && match) begin
        irq_stat_reg[IRQ_CMPA] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= take;
      wb_dat_o <= '0;
      if (rd) begin
        case (wb_req_i.adr)
          ADR_CTRL_A: wb_dat_o[7:0] <= waveform_control_a_reg;
          ADR_CTRL_B: wb_dat_o[7:0] <= waveform_control_b_reg;
          ADR_COUNT: wb_dat_o[7:0] <= count_value_reg;
          ADR_CMP_A: wb_dat_o[7:0] <= cmp_buf_reg;
          ADR_IRQ_STAT: wb_dat_o[1:0] <= irq_stat_reg;
          ADR_IRQ_MASK: wb_dat_o[1:0] <= irq_mask_reg;
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic cnt_wr;
  assign cnt_wr = wr && wb_req_i.adr == ADR_COUNT;

  AST_PC_TURN_AT_TOP: assert property (
    is_pc && timer_tick && dir_reg == DIR_UP && count_value_reg == top && top != CNT_BOTTOM && !cnt_wr
    |=> dir_reg == DIR_DOWN && count_value_reg == $past(count_value_reg) - CNT_ONE)
    else $error("counter did not turn at top");
  AST_PC_TOP_MAX: assert property (
    waveform_mode_select == MODE_PC_MAX && timer_tick && dir_reg == DIR_UP && count_value_reg == CNT_MAX
    |=> dir_reg == DIR_DOWN)
    else $error("top is not 0xFF in selection 1");
  AST_OVF_AT_BOTTOM: assert property (
    is_pc && timer_tick && dir_reg == DIR_DOWN && count_value_reg == CNT_ONE |=> irq_stat_reg[IRQ_OVF])
    else $error("overflow flag missing at bottom");
  AST_CLEAR_ON_UP: assert property (
    is_pc && timer_tick && !force_a && dir_reg == DIR_UP && match && !ignore_match &&
    output_a_action == ACT_CLEAR |=> !compare_output_a_o)
    else $error("output not cleared on up match");
  AST_SET_ON_DOWN: assert property (
    is_pc && timer_tick && dir_reg == DIR_DOWN && count_value_reg != CNT_BOTTOM && match &&
    !ignore_match && output_a_action == ACT_CLEAR |=> compare_output_a_o)
    else $error("output not set on down match");
  AST_TOGGLE_NON_PWM: assert property (
    !is_pwm && timer_tick && !force_a && match && output_a_action == ACT_TOGGLE
    |=> compare_output_a_o != $past(compare_output_a_o))
    else $error("toggle on match missing");
  AST_OE_ROUTE: assert property (
    output_a_action == ACT_SET |=> compare_output_a_oe_o)
    else $error("output not routed to pin");
  AST_DIR_UP_AT_BOTTOM: assert property (
    is_pc && timer_tick && count_value_reg == CNT_BOTTOM |=> dir_reg == DIR_UP)
    else $error("direction not up at bottom");
  AST_STILL_WITHOUT_TICK: assert property (
    !timer_tick && !cnt_wr |=> $stable(count_value_reg))
    else $error("counter moved without a tick");
  AST_FAST_SET_AT_TOP: assert property (
    is_fast && timer_tick && count_value_reg >= top && output_a_action == ACT_CLEAR |=> compare_output_a_o)
    else $error("fast pwm top action missing");

  COV_PC_TURN: cover property (is_pc && turn_evt);
  COV_PC_BOTTOM_OVF: cover property (is_pc && ovf_evt);
  COV_IRQ: cover property (irq_o);
  AST_BOTTOM_STEADY_LOW: assert property (
    waveform_mode_select == MODE_PC_MAX && timer_tick && dir_reg == DIR_UP && output_a_action == ACT_CLEAR &&
    compare_value_a_reg == CNT_BOTTOM |=> !compare_output_a_o)
    else $error("bottom compare value did not hold the output low");
  AST_MAX_STEADY_HIGH: assert property (
    is_pc && timer_tick && turn_evt && output_a_action == ACT_CLEAR && compare_value_a_reg == top
    |=> compare_output_a_o)
    else $error("top action missing with compare equal to top");
  AST_MISSED_UP_MATCH: assert property (
    is_pc && timer_tick && output_a_action[1] && dir_reg == DIR_UP && !turn_evt &&
    count_value_reg > compare_value_a_reg |=> compare_output_a_o == $past(up_lvl))
    else $error("missed up match level not applied");

  COV_FAST_WRAP: cover property (is_fast && upd_evt);
  COV_MISSED_MATCH: cover property (is_pc && timer_tick && dir_reg == DIR_UP && count_value_reg > top);
endmodule // dsptu_top

// >>> tb/dsptu_load.sv
// external load on the compare pin, with a pull-down on the wire
// assumes the bench supplies the pin direction bit that software would set
`timescale 1ns/1ps
module dsptu_load (
  // timer side of the pin
  input wire logic level_i,
  input wire logic oe_i,
  // port direction bit
  input wire logic dir_i,
  // wire level seen by the load
  output logic pin_o
);
  // the wire only follows the timer with the route and the driver both on
  assign pin_o = (oe_i & dir_i) ? level_i : 1'b0;
endmodule // dsptu_load

// >>> tb/tb.sv
// self-checking bench for the dual-slope pwm timer unit
// assumes dsptu_pkg, dsptu_top and dsptu_load are compiled first
`timescale 1ns/1ps
module tb;
  import dsptu_pkg::*;
  typedef struct packed {
    logic [1:0] act;
    logic [2:0] mode;
    logic [2:0] cs;
    logic [7:0] cmp;
    logic [15:0] hi;
    logic oe;
    logic [15:0] per;
  } dsptu_row_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic dir_out = 1'b0;
  dsptu_wb_req_s wb_req = '0;
  logic [31:0] wb_dat;
  logic wb_ack;
  logic pin_lvl;
  logic pin_oe;
  logic irq;
  logic pin;
  logic [31:0] rd;
  logic [15:0] n;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  dsptu_row_s rows [12];
  logic [7:0] adrs [6];
  logic [7:0] wexp [6];
  logic [1:0] fact [4];
  logic fexp [4];

  dsptu_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
    .compare_output_a_o(pin_lvl), .compare_output_a_oe_o(pin_oe), .irq_o(irq));
  dsptu_load LOAD (.level_i(pin_lvl), .oe_i(pin_oe), .dir_i(dir_out), .pin_o(pin));

  always #5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errors = errors + 1;
      conclude();
    end
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(logic we, logic [7:0] adr, logic [7:0] dat);
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h000000, dat}};
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rd = wb_dat;
    wb_req <= '0;
  endtask

  // compare value is loaded while stopped in normal mode, so it is active at once
  task automatic setup(logic [1:0] act, logic [2:0] mode, logic [2:0] cs, logic [7:0] cmp);
    wb(1'b1, ADR_CTRL_B, 8'h00);
    wb(1'b1, ADR_CTRL_A, 8'h00);
    wb(1'b1, ADR_COUNT, CNT_BOTTOM);
    wb(1'b1, ADR_CMP_A, cmp);
    wb(1'b1, ADR_CTRL_A, {act, 4'h0, mode[1:0]});
    wb(1'b1, ADR_CTRL_B, {4'h0, mode[2], cs});
  endtask

  // cycles between the last two overflow interrupts
  task automatic ovf_gap(output logic [15:0] gap);
    time t0;
    time t1;
    t1 = 0;
    wb(1'b1, ADR_IRQ_MASK, 8'h01);
    repeat (3) begin
      wb(1'b0, ADR_IRQ_STAT, 8'h00);
      repeat (2) @(posedge clk_i);
      do @(posedge clk_i); while (irq !== 1'b1);
      t0 = t1;
      t1 = $time;
    end
    gap = 16'((t1 - t0) / 10);
  endtask

  task automatic highs(logic [15:0] len, output logic [15:0] hi);
    hi = 16'h0000;
    repeat (len) begin
      @(posedge clk_i);
      hi = hi + {15'h0000, pin === 1'b1};
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{
      '{ACT_CLEAR, MODE_PC_MAX, 3'h1, 8'h40, 16'h0080, 1'b1, 16'(PC_PERIOD_TICKS)},
      '{ACT_SET, MODE_PC_MAX, 3'h1, 8'h40, 16'h017E, 1'b1, 16'(PC_PERIOD_TICKS)},
      '{ACT_CLEAR, MODE_PC_MAX, 3'h1, CNT_BOTTOM, 16'h0000, 1'b1, 16'(PC_PERIOD_TICKS)},
      '{ACT_CLEAR, MODE_PC_MAX, 3'h1, CNT_MAX, 16'h01FE, 1'b1, 16'(PC_PERIOD_TICKS)},
      '{ACT_SET, MODE_PC_MAX, 3'h1, CNT_BOTTOM, 16'h01FE, 1'b1, 16'(PC_PERIOD_TICKS)},
      '{ACT_SET, MODE_PC_MAX, 3'h1, CNT_MAX, 16'h0000, 1'b1, 16'(PC_PERIOD_TICKS)},
      '{ACT_OFF, MODE_PC_MAX, 3'h1, 8'h40, 16'h0000, 1'b0, 16'(PC_PERIOD_TICKS)},
      '{ACT_TOGGLE, MODE_PC_MAX, 3'h1, 8'h40, 16'h0000, 1'b0, 16'(PC_PERIOD_TICKS)},
      '{ACT_CLEAR, MODE_PC_MAX, 3'h2, 8'h40, 16'h0400, 1'b1, 16'h0FF0},
      '{ACT_OFF, MODE_PC_CMP, 3'h1, 8'h20, 16'h0000, 1'b0, 16'h0040},
      '{ACT_CLEAR, MODE_PC_CMP, 3'h1, 8'h20, 16'h0040, 1'b1, 16'h0040},
      '{ACT_CLEAR, MODE_FAST_MAX, 3'h1, 8'h40, 16'h0041, 1'b1, 16'h0100}};
    adrs = '{ADR_CTRL_A, ADR_CTRL_B, ADR_COUNT, ADR_CMP_A, ADR_IRQ_MASK, 8'h18};
    wexp = '{CTRL_A_WR_MASK, CTRL_B_WR_MASK, 8'hFF, 8'hFF, {6'h00, IRQ_WR_MASK}, 8'h00};
    fact = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_TOGGLE};
    fexp = '{1'b1, 1'b0, 1'b1, 1'b0};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    dir_out <= 1'b1;
    foreach (rows[i]) begin
      setup(rows[i].act, rows[i].mode, rows[i].cs, rows[i].cmp);
      ovf_gap(n);
      check("overflow period", {16'h0000, n}, {16'h0000, rows[i].per});
      highs(rows[i].per, n);
      check("high cycles", {16'h0000, n}, {16'h0000, rows[i].hi});
      check("pin enable", {31'h0, pin_oe}, {31'h0, rows[i].oe});
    end
    // second reset in mid-run, then reset values and access kinds
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("outputs after reset", {29'h0, pin_lvl, pin_oe, irq}, 32'h0);
    foreach (adrs[i]) begin
      wb(1'b0, adrs[i], 8'h00);
      check("reset value", rd, {24'h000000, RST_BYTE});
      wb(1'b1, adrs[i], 8'hFF);
      wb(1'b0, adrs[i], 8'h00);
      check("read back", rd, {24'h000000, wexp[i]});
    end
    // forced matches in normal mode with the timer stopped
    setup(ACT_SET, MODE_NORMAL, 3'h0, 8'h40);
    foreach (fact[i]) begin
      wb(1'b1, ADR_CTRL_A, {fact[i], 6'h00});
      wb(1'b1, ADR_CTRL_B, 8'h80);
      repeat (3) @(posedge clk_i);
      check("forced level", {31'h0, pin}, {31'h0, fexp[i]});
    end
    // start above the compare value with the pin high
    wb(1'b1, ADR_CTRL_A, {ACT_SET, 6'h00});
    wb(1'b1, ADR_CTRL_B, 8'h80);
    wb(1'b1, ADR_COUNT, 8'h80);
    wb(1'b1, ADR_CTRL_A, {ACT_CLEAR, 4'h0, MODE_PC_MAX[1:0]});
    wb(1'b1, ADR_CTRL_B, 8'h01);
    repeat (20) @(posedge clk_i);
    check("missed up match", {31'h0, pin}, 32'h0);
    // masked events, then read-clear with the timer stopped
    setup(ACT_OFF, MODE_PC_MAX, 3'h1, 8'h40);
    wb(1'b1, ADR_IRQ_MASK, 8'h00);
    wb(1'b0, ADR_IRQ_STAT, 8'h00);
    repeat (600) @(posedge clk_i);
    check("masked irq", {31'h0, irq}, 32'h0);
    wb(1'b0, ADR_IRQ_STAT, 8'h00);
    check("sticky status", rd, 32'h3);
    wb(1'b1, ADR_CTRL_B, 8'h00);
    wb(1'b0, ADR_IRQ_STAT, 8'h00);
    wb(1'b0, ADR_IRQ_STAT, 8'h00);
    check("cleared status", rd, 32'h0);
    wb(1'b1, ADR_IRQ_MASK, 8'h03);
    repeat (3) @(posedge clk_i);
    check("irq after clear", {31'h0, irq}, 32'h0);
    conclude();
  end
endmodule // tb
